// ### bench/buck_setpoint_properties.sv
// bound checker for the set-point decoder
`timescale 1ns/1ps
module buck_setpoint_checker
    import buck_setpoint_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic otp_programmed_i,
    input wire logic otp_range_select_i,
    input wire logic normal_write_i,
    input wire logic [CODE_W-1:0] write_data_i,
    input wire op_mode_t op_mode_i,
    input wire setpoint_view_t view_o,
    input wire logic [CODE_W-1:0] active_code_o,
    input wire logic [MV_W-1:0] target_mv_o,
    input wire logic target_valid_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    sequence s_cap; $fell(reset_i) ##1 1'b1; endsequence
    property p_ro; !$past(reset_i, 2) |-> $stable(view_o.normal_code[6]); endproperty
    property p_otp; s_cap |-> view_o.normal_code[6] == (otp_programmed_i ? otp_range_select_i : RANGE_DEFAULT); endproperty
    property p_low; target_valid_o && !active_code_o[6] |-> target_mv_o == LOW_BASE_MV + LOW_STEP_MV * active_code_o[5:0];
    endproperty
    property p_high; target_valid_o && active_code_o[6] |-> target_mv_o == HIGH_BASE_MV + HIGH_STEP_MV * active_code_o[5:0];
    endproperty
    property p_val; !$past(reset_i) |-> target_valid_o == (!active_code_o[6] || active_code_o[5:0] <= 6'h32); endproperty
    property p_sel; !$past(reset_i) |-> active_code_o == ($past(op_mode_i) == MODE_STANDBY ? view_o.standby_code :
        $past(op_mode_i) == MODE_SLEEP ? view_o.sleep_code : view_o.normal_code); endproperty
    property p_rng; view_o.standby_code[6] == view_o.normal_code[6] && view_o.sleep_code[6] == view_o.normal_code[6];
    endproperty
    property p_wr; normal_write_i |=> view_o.normal_code[5:0] == $past(write_data_i[5:0]); endproperty
    a_ro: assert property (p_ro) else $error("range bit moved");
    a_otp: assert property (p_otp) else $error("range source wrong");
    a_low: assert property (p_low) else $error("low decode wrong");
    a_high: assert property (p_high) else $error("high decode wrong");
    a_val: assert property (p_val) else $error("valid flag wrong");
    a_sel: assert property (p_sel) else $error("wrong mode code");
    a_rng: assert property (p_rng) else $error("range copies differ");
    a_wr: assert property (p_wr) else $error("write not seen");
endmodule // buck_setpoint_checker
bind buck_setpoint_range_decode buck_setpoint_checker buck_setpoint_checker_inst (.*);

// ### bench/tb_top.sv
// self-checking bench for the set-point decoder
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; $display("[ERR] %0t got %h", $time, a); end end
module tb_top;
    import buck_setpoint_pkg::*;
    logic clock_i = 0, reset_i = 1, otp_programmed_i = 0, otp_range_select_i = 0, r;
    logic normal_write_i = 0, standby_write_i = 0, sleep_write_i = 0;
    logic [6:0] write_data_i = 0, d;
    op_mode_t op_mode_i = MODE_NORMAL;
    setpoint_view_t view_o;
    logic [6:0] active_code_o;
    logic [11:0] target_mv_o;
    logic target_valid_o, v;
    logic [40:0] q[$], n, e;
    logic [5:0] f[3];
    logic [2:0] w;
    int failures = 0, comparisons = 0, cyc = 0, k, m, s, lo;
    always #4 clock_i = ~clock_i;
    buck_setpoint_range_decode buck_setpoint_range_decode_inst (.*);
    task automatic close_out;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clock_i)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            failures++;
            close_out;
        end
        if (q.size() > 0)
        begin
            e = q.pop_front();
            #2 `CHK({view_o, active_code_o, target_mv_o, target_valid_o}, e)
        end
    end
    initial
    begin
        void'($urandom(48278));
        for (k = 0; k < 3; k++)
        begin
            @(posedge clock_i);
            {normal_write_i, standby_write_i, sleep_write_i} <= 3'h0;
            {reset_i, otp_programmed_i, otp_range_select_i} <= {1'b1, k > 0, k == 1};
            repeat (12) @(posedge clock_i);
            reset_i <= 0;
            r = k == 1;
            f = '{default: 6'h00};
            repeat (300)
            begin
                @(posedge clock_i);
                lo = r ? 24 : 9;
                w = 3'($urandom);
                m = $urandom % 4;
                d = {1'($urandom), 6'(lo + $urandom % (64 - lo))};
                {normal_write_i, standby_write_i, sleep_write_i} <= w;
                write_data_i <= d;
                op_mode_i <= op_mode_t'(m);
                foreach (f[j])
                    if (w[2 - j]) f[j] = d[5:0];
                s = m == 1 ? 1 : m == 2 ? 2 : 0;
                v = !r || f[s] <= 6'h32;
                n = r ? HIGH_BASE_MV + HIGH_STEP_MV * f[s] : LOW_BASE_MV + LOW_STEP_MV * f[s];
                #1 q.push_back({r, f[0], r, f[1], r, f[2], r, f[s], v ? n[11:0] : 12'h000, v});
            end
        end
        repeat (3) @(posedge clock_i);
        close_out;
    end
endmodule // tb_top

// ### hw/buck_setpoint_pkg.sv
// constants and types for the buck set-point range decoder
package buck_setpoint_pkg;
    localparam int SETPOINT_W = 6;
    localparam int CODE_W = 7;
    localparam int MV_W = 12;
    localparam logic [SETPOINT_W-1:0] SETPOINT_RESET = 6'h00;
    localparam logic RANGE_DEFAULT = 1'b0;
    localparam int RANGE_BIT_POS = 6;
    localparam logic [MV_W-1:0] LOW_BASE_MV = 12'h190;
    localparam logic [MV_W-1:0] LOW_STEP_MV = 12'h019;
    localparam logic [MV_W-1:0] HIGH_BASE_MV = 12'h320;
    localparam logic [MV_W-1:0] HIGH_STEP_MV = 12'h032;
    localparam logic [MV_W-1:0] HIGH_MAX_MV = 12'hce4;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_STANDBY = 2'b01,
        MODE_SLEEP = 2'b10
    } op_mode_t;

    typedef struct packed {
        logic [CODE_W-1:0] normal_code;
        logic [CODE_W-1:0] standby_code;
        logic [CODE_W-1:0] sleep_code;
    } setpoint_view_t;

    typedef struct packed {
        logic [SETPOINT_W-1:0] normal_setpoint_field;
        logic [SETPOINT_W-1:0] standby_setpoint_field;
        logic [SETPOINT_W-1:0] sleep_setpoint_field;
        logic range_select_bit;
        logic range_captured;
        logic [CODE_W-1:0] active_code;
        logic [MV_W-1:0] target_mv;
        logic target_valid;
        setpoint_view_t view;
    } setpoint_state_t;
endpackage

// ### hw/buck_setpoint_range_decode.sv
// set-point bank and range decode for one buck regulator
// Functional notes
// - range bit ignores run-time writes
// - range bit comes from default or OTP
// - low range: 0.400 V plus 25 mV steps
// - high range: 0.800 V plus 50 mV steps
// - three set-point fields, current mode applied
// - range bit copied into standby and sleep
// - code is range bit then step count
// - standby and sleep range bits read-only copies
`timescale 1ns/1ps
module buck_setpoint_range_decode
    import buck_setpoint_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // configuration source
    input wire logic otp_programmed_i,
    input wire logic otp_range_select_i,
    // set-point writes
    input wire logic normal_write_i,
    input wire logic standby_write_i,
    input wire logic sleep_write_i,
    input wire logic [CODE_W-1:0] write_data_i,
    // operating mode
    input wire op_mode_t op_mode_i,
    // readback and decoded target
    output setpoint_view_t view_o,
    output logic [CODE_W-1:0] active_code_o,
    output logic [MV_W-1:0] target_mv_o,
    output logic target_valid_o
);
    setpoint_state_t state;
    setpoint_state_t next_state;
    logic [CODE_W-1:0] next_code;
    logic [MV_W-1:0] dec_mv;
    logic dec_valid;

    setpoint_code_decode u_decode (
        .code_i(next_code),
        .target_mv_o(dec_mv),
        .valid_o(dec_valid)
    );

    always_comb
    begin
        next_state = state;
        // range bit latched once after reset, never from writes
        if (!state.range_captured)
        begin
            next_state.range_select_bit = otp_programmed_i ? otp_range_select_i : RANGE_DEFAULT;
            next_state.range_captured = 1'b1;
        end
        // only bits 5:0 of a write are stored
        if (normal_write_i)
        begin
            next_state.normal_setpoint_field = write_data_i[SETPOINT_W-1:0];
        end
        if (standby_write_i)
        begin
            next_state.standby_setpoint_field = write_data_i[SETPOINT_W-1:0];
        end
        if (sleep_write_i)
        begin
            next_state.sleep_setpoint_field = write_data_i[SETPOINT_W-1:0];
        end
        next_state.view.normal_code = {next_state.range_select_bit, next_state.normal_setpoint_field};
        next_state.view.standby_code = {next_state.range_select_bit, next_state.standby_setpoint_field};
        next_state.view.sleep_code = {next_state.range_select_bit, next_state.sleep_setpoint_field};
        unique case (op_mode_i)
            MODE_NORMAL: next_code = next_state.view.normal_code;
            MODE_STANDBY: next_code = next_state.view.standby_code;
            MODE_SLEEP: next_code = next_state.view.sleep_code;
            default: next_code = next_state.view.normal_code;
        endcase
        next_state.active_code = next_code;
        next_state.target_mv = dec_mv;
        next_state.target_valid = dec_valid;
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            state <= '0;
            state.normal_setpoint_field <= SETPOINT_RESET;
            state.standby_setpoint_field <= SETPOINT_RESET;
            state.sleep_setpoint_field <= SETPOINT_RESET;
            state.range_select_bit <= RANGE_DEFAULT;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign view_o = state.view;
    assign active_code_o = state.active_code;
    assign target_mv_o = state.target_mv;
    assign target_valid_o = state.target_valid;
endmodule // buck_setpoint_range_decode

// ### hw/setpoint_code_decode.sv
// combinational decode of a 7-bit set-point code into millivolts
`timescale 1ns/1ps
module setpoint_code_decode
    import buck_setpoint_pkg::*;
(
    // code in
    input wire logic [CODE_W-1:0] code_i,
    // decoded target
    output logic [MV_W-1:0] target_mv_o,
    output logic valid_o
);
    logic [MV_W-1:0] steps;
    logic [MV_W-1:0] raw;

    always_comb
    begin
        steps = {{(MV_W-SETPOINT_W){1'b0}}, code_i[SETPOINT_W-1:0]};
        if (code_i[RANGE_BIT_POS])
        begin
            raw = 12'(HIGH_BASE_MV + 12'(steps * HIGH_STEP_MV));
        end
        else
        begin
            raw = 12'(LOW_BASE_MV + 12'(steps * LOW_STEP_MV));
        end
        valid_o = !(code_i[RANGE_BIT_POS] && raw > HIGH_MAX_MV);
        target_mv_o = valid_o ? raw : '0;
    end
endmodule // setpoint_code_decode
